// ===== src/fiet_top.sv
// Sixteen-channel fast input block with filters, edge interrupts and time stamps
`default_nettype none
`include "fiet_params.svh"
module fiet_top #(
  parameter int STEP_CYCLES = `FIET_STEP_CYCLES,
  parameter int DELAY_CYCLES = `FIET_DELAY_CYCLES,
  parameter int TICK_CYCLES = `FIET_TICK_CYCLES,
  parameter int DELAY_DEPTH = `FIET_DELAY_DEPTH
) (
  input wire logic clock, // 200 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic ext_mode, // Extended configuration present
  input wire logic cpu_boot, // CPU boot pulse, restarts timer
  input wire logic [15:0] pin_in, // Raw input pins
  input wire fiet_pkg::fiet_rec_wr_type rec_wr, // Parameter record byte write
  input wire fiet_pkg::fiet_img_req_type img_req, // Input image byte read
  input wire logic [15:0] proc_irq_ack, // Service done per channel
  output fiet_pkg::fiet_img_rsp_type img_rsp, // Read answer
  output logic [15:0] proc_irq_vec, // Process interrupt request pulses
  output logic diag_irq, // Diagnostic interrupt pulse
  output logic [15:0] diag_chan // Channels causing diagnostic
);

  localparam int CW = 24;

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic ext_q;
    logic running;
    logic [15:0] pre;
    logic [31:0] timer;
    logic [15:0] diag_word;
    logic [15:0][1:0] isel;
    logic [15:0][1:0] ssel;
    logic [15:0][15:0] factor;
    logic [15:0] filt_prev;
    logic [15:0] flags;
    logic [15:0] lost;
    logic [15:0] pending;
    logic [15:0][15:0] stamp;
    fiet_pkg::fiet_img_rsp_type img_rsp;
    logic [15:0] proc_irq_vec;
    logic diag_irq;
    logic [15:0] diag_chan;
  } fiet_top_state_type;

  fiet_top_state_type st;
  fiet_top_state_type next_st;
  logic [15:0] delayed;
  logic [15:0] filtered;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] clr_flags;
  logic [15:0] clr_lost;

  if (STEP_CYCLES < 1 || TICK_CYCLES < 1 || TICK_CYCLES > 65535
      || longint'(STEP_CYCLES) * 16000 >= (longint'(1) << CW)) begin : g_chk
    $error("fiet_top: timing parameters unusable");
  end

  function automatic logic [CW-1:0] filter_limit(input logic [15:0] raw);
    logic [15:0] f;
    f = raw;
    if (raw < `FIET_FACTOR_MIN) begin
      f = `FIET_FACTOR_MIN;
    end else if (raw > `FIET_FACTOR_MAX) begin
      f = `FIET_FACTOR_MAX;
    end
    return CW'(f * CW'(STEP_CYCLES));
  endfunction

  function automatic logic edge_match(input logic [1:0] sel, input logic r, input logic fl);
    return (sel[0] & r) | (sel[1] & fl);
  endfunction

  function automatic logic [7:0] img_byte(input fiet_top_state_type s, input logic [5:0] a);
    logic [5:0] idx;
    logic [15:0] w;
    idx = a - `FIET_IMG_STAMP;
    w = s.stamp[idx[4:1]];
    if (!s.ext_q && a >= `FIET_IMG_BASIC_LEN) begin
      return 8'h00;
    end
    case (a)
      `FIET_IMG_STATE: return s.filt_prev[7:0];
      `FIET_IMG_STATE + 6'h01: return s.filt_prev[15:8];
      `FIET_IMG_FLAGS: return s.flags[7:0];
      `FIET_IMG_FLAGS + 6'h01: return s.flags[15:8];
      `FIET_IMG_LOST: return s.lost[7:0];
      `FIET_IMG_LOST + 6'h01: return s.lost[15:8];
      default: begin
        if (a >= `FIET_IMG_STAMP && a < `FIET_IMG_STAMP_END) begin
          return idx[0] ? w[15:8] : w[7:0];
        end
        return 8'h00;
      end
    endcase
  endfunction

  // Fixed extended-mode delay ahead of the filters
  fiet_delay_mem #(
    .WIDTH(16),
    .DEPTH(DELAY_DEPTH),
    .DELAY(DELAY_CYCLES)
  ) u_delay (
    .clock(clock),
    .sys_rst(sys_rst),
    .wdata(st.sync2),
    .rdata(delayed)
  );

  for (genvar i = 0; i < 16; i++) begin : g_filt
    fiet_filter #(
      .CNT_W(CW)
    ) u_filt (
      .clock(clock),
      .sys_rst(sys_rst),
      .raw_in(st.ext_q ? delayed[i] : st.sync2[i]),
      .limit(st.ext_q ? filter_limit(st.factor[i]) : CW'(STEP_CYCLES)),
      .filt_out(filtered[i])
    );
  end

  assign rise = filtered & ~st.filt_prev;
  assign fall = ~filtered & st.filt_prev;
  assign clr_flags = {{8{img_req.valid && st.ext_q && img_req.addr == `FIET_IMG_FLAGS + 6'h01}},
                      {8{img_req.valid && st.ext_q && img_req.addr == `FIET_IMG_FLAGS}}};
  assign clr_lost = {{8{img_req.valid && st.ext_q && img_req.addr == `FIET_IMG_LOST + 6'h01}},
                     {8{img_req.valid && st.ext_q && img_req.addr == `FIET_IMG_LOST}}};

  always_comb begin
    next_st = st;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    next_st.ext_q = ext_mode;
    next_st.filt_prev = filtered;
    next_st.proc_irq_vec = '0;
    next_st.diag_irq = 1'b0;
    next_st.diag_chan = '0;
    next_st.img_rsp = '0;
    // Microsecond timer
    if (cpu_boot) begin
      next_st.running = 1'b1;
      next_st.timer = '0;
      next_st.pre = '0;
    end else if (st.running) begin
      if (st.pre == 16'(TICK_CYCLES - 1)) begin
        next_st.pre = '0;
        next_st.timer = st.timer + 32'h00000001;
      end else begin
        next_st.pre = st.pre + 16'h0001;
      end
    end
    // Parameter records, refused in basic mode
    if (rec_wr.valid && st.ext_q) begin
      case (rec_wr.num)
        `FIET_REC_DIAG: begin
          if (rec_wr.idx == `FIET_DIAG_OFS) begin
            next_st.diag_word[15:8] = rec_wr.data;
          end else if (rec_wr.idx == `FIET_DIAG_OFS + 7'h01) begin
            next_st.diag_word[7:0] = rec_wr.data;
          end
        end
        `FIET_REC_EDGE: begin
          if (rec_wr.idx < `FIET_STAMP_SEL_OFS) begin
            next_st.isel[rec_wr.idx[3:0]] = rec_wr.data[1:0];
          end else if (rec_wr.idx < `FIET_EDGE_REC_LEN) begin
            next_st.ssel[rec_wr.idx[3:0]] = rec_wr.data[1:0];
          end
        end
        `FIET_REC_FILT: begin
          if (rec_wr.idx < `FIET_FILT_LEN) begin
            if (rec_wr.idx[0]) begin
              next_st.factor[rec_wr.idx[4:1]][7:0] = rec_wr.data;
            end else begin
              next_st.factor[rec_wr.idx[4:1]][15:8] = rec_wr.data;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Image read with clear-on-read of flag bytes
    if (img_req.valid) begin
      next_st.img_rsp.valid = 1'b1;
      next_st.img_rsp.data = img_byte(st, img_req.addr);
    end
    next_st.flags = st.flags & ~clr_flags;
    next_st.lost = st.lost & ~clr_lost;
    next_st.pending = st.pending & ~proc_irq_ack;
    // Edge events win over clears
    for (int i = 0; i < 16; i++) begin
      if (st.ext_q && (rise[i] || fall[i])) begin
        if (st.flags[i] && !clr_flags[i]) begin
          next_st.lost[i] = 1'b1;
        end
        next_st.flags[i] = 1'b1;
        if (edge_match(st.ssel[i], rise[i], fall[i])) begin
          next_st.stamp[i] = st.timer[15:0];
        end
        if (edge_match(st.isel[i], rise[i], fall[i])) begin
          next_st.proc_irq_vec[i] = 1'b1;
          next_st.pending[i] = 1'b1;
          if (st.pending[i] && st.diag_word == `FIET_DIAG_ON) begin
            next_st.diag_irq = 1'b1;
            next_st.diag_chan[i] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
      st.diag_word <= `FIET_DIAG_RESET;
      st.isel <= {16{`FIET_SEL_RESET}};
      st.ssel <= {16{`FIET_SEL_RESET}};
      st.factor <= {16{`FIET_FACTOR_RESET}};
    end else begin
      st <= next_st;
    end
  end

  assign img_rsp = st.img_rsp;
  assign proc_irq_vec = st.proc_irq_vec;
  assign diag_irq = st.diag_irq;
  assign diag_chan = st.diag_chan;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_stamp_edge0;
    st.ext_q && edge_match(st.ssel[0], rise[0], fall[0]);
  endsequence

  sequence s_retrigger0;
    st.ext_q && edge_match(st.isel[0], rise[0], fall[0]) && st.pending[0] && !proc_irq_ack[0];
  endsequence

  AST_BASIC_REFUSE: assert property (rec_wr.valid && !st.ext_q |=>
    $stable(st.factor) && $stable(st.isel) && $stable(st.ssel) && $stable(st.diag_word))
    else $error("parameter write taken in basic mode");
  AST_BASIC_IMAGE: assert property (img_req.valid && !st.ext_q
    && img_req.addr >= `FIET_IMG_BASIC_LEN |=> img_rsp.valid && img_rsp.data == 8'h00)
    else $error("basic mode image beyond two bytes not zero");
  AST_DIAG_GATE: assert property (diag_irq |-> $past(st.diag_word) == `FIET_DIAG_ON)
    else $error("diagnostic interrupt while disabled");
  AST_DIAG_CAUSE: assert property ((s_retrigger0 and st.diag_word == `FIET_DIAG_ON)
    |=> diag_irq && diag_chan[0] && proc_irq_vec[0])
    else $error("retrigger did not raise diagnostic interrupt");
  AST_IRQ_SEL: assert property (st.ext_q && rise[0] && st.isel[0] == 2'h2
    |=> !proc_irq_vec[0])
    else $error("falling-only selection fired on rising edge");
  AST_IRQ_ONE: assert property (proc_irq_vec[1] |-> $past(st.ext_q)
    && $past(edge_match(st.isel[1], rise[1], fall[1])))
    else $error("process interrupt without matching edge");
  AST_TIMER_TICK: assert property (st.running && !cpu_boot
    && st.pre == 16'(TICK_CYCLES - 1) |=> st.timer == $past(st.timer) + 32'h00000001)
    else $error("timer did not advance on tick");
  AST_STAMP: assert property (s_stamp_edge0 |=> st.stamp[0] == $past(st.timer[15:0]))
    else $error("time stamp not captured");
  AST_FLAG_CLEAR: assert property (clr_flags[2] && !rise[2] && !fall[2] |=> !st.flags[2])
    else $error("edge flag not cleared by read");
  AST_LOST: assert property (st.ext_q && rise[3] && st.flags[3] && !clr_flags[3]
    |=> st.lost[3] && st.flags[3])
    else $error("edge lost not flagged");
  AST_STAMP_READ: assert property (img_req.valid && st.ext_q
    && img_req.addr == `FIET_IMG_STAMP + 6'h03 |=> img_rsp.data == $past(st.stamp[1][15:8]))
    else $error("stamp slot byte mismatch");
  AST_STAMP_HOLD: assert property (st.ext_q && (rise[0] || fall[0])
    && !edge_match(st.ssel[0], rise[0], fall[0]) |=> $stable(st.stamp[0]))
    else $error("time stamp taken on an unselected edge");
  AST_PEND_CLEAR: assert property (proc_irq_ack[2]
    && !(st.ext_q && edge_match(st.isel[2], rise[2], fall[2])) |=> !st.pending[2])
    else $error("service done did not clear pending");
  AST_DIAG_RSV: assert property (rec_wr.valid && st.ext_q && rec_wr.num == `FIET_REC_DIAG
    && rec_wr.idx >= 7'h02 |=> $stable(st.diag_word))
    else $error("reserved diagnostic word changed the control word");

endmodule // fiet_top
`default_nettype wire

// ===== src/fiet_params.svh
// Constants of the fast input edge time-stamp block
`ifndef FIET_PARAMS_SVH
`define FIET_PARAMS_SVH

`define FIET_CLK_PERIOD_PS 5000
`define FIET_STEP_PS 2560000
`define FIET_FIXED_DELAY_PS 1000000
`define FIET_TIMER_RES_PS 1000000
`define FIET_STEP_CYCLES ((`FIET_STEP_PS + `FIET_CLK_PERIOD_PS - 1) / `FIET_CLK_PERIOD_PS)
`define FIET_DELAY_CYCLES ((`FIET_FIXED_DELAY_PS + `FIET_CLK_PERIOD_PS - 1) / `FIET_CLK_PERIOD_PS)
`define FIET_TICK_CYCLES (`FIET_TIMER_RES_PS / `FIET_CLK_PERIOD_PS)
`define FIET_DELAY_DEPTH 256

`define FIET_REC_DIAG 8'h7F
`define FIET_REC_EDGE 8'h80
`define FIET_REC_FILT 8'h81
`define FIET_DIAG_OFS 7'h00
`define FIET_DIAG_LEN 7'h04
`define FIET_EDGE_SEL_OFS 7'h00
`define FIET_STAMP_SEL_OFS 7'h10
`define FIET_EDGE_REC_LEN 7'h20
`define FIET_FILT_OFS 7'h00
`define FIET_FILT_LEN 7'h20

`define FIET_DIAG_OFF 16'h0000
`define FIET_DIAG_ON 16'h0001
`define FIET_DIAG_RESET 16'h0000
`define FIET_SEL_RESET 2'h0
`define FIET_FACTOR_RESET 16'h0001
`define FIET_FACTOR_MIN 16'h0001
`define FIET_FACTOR_MAX 16'h3E80

`define FIET_IMG_STATE 6'h00
`define FIET_IMG_FLAGS 6'h04
`define FIET_IMG_LOST 6'h08
`define FIET_IMG_STAMP 6'h0C
`define FIET_IMG_STAMP_END 6'h2C
`define FIET_IMG_BASIC_LEN 6'h02
`define FIET_IMG_EXT_LEN 6'h30

`endif

// ===== src/fiet_pkg.sv
// Types shared by the fast input edge time-stamp block
`default_nettype none
package fiet_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] num;
    logic [6:0] idx;
    logic [7:0] data;
  } fiet_rec_wr_type;

  typedef struct packed {
    logic valid;
    logic [5:0] addr;
  } fiet_img_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fiet_img_rsp_type;

  typedef enum logic [1:0] {
    FIET_EDGE_NONE,
    FIET_EDGE_RISE,
    FIET_EDGE_FALL,
    FIET_EDGE_BOTH
  } fiet_edge_sel_type;

endpackage : fiet_pkg
`default_nettype wire

// ===== src/fiet_filter.sv
// Per-channel input filter: output follows input after a stable run
`default_nettype none
module fiet_filter #(
  parameter int CNT_W = 24
) (
  input wire logic clock, // 200 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic raw_in, // Unfiltered level
  input wire logic [CNT_W-1:0] limit, // Stable cycles required
  output logic filt_out // Filtered level
);

  typedef struct packed {
    logic out;
    logic [CNT_W-1:0] cnt;
  } fiet_filter_state_type;

  fiet_filter_state_type st;
  fiet_filter_state_type next_st;

  if (CNT_W < 2) begin : g_chk
    $error("fiet_filter: CNT_W too small");
  end

  always_comb begin
    next_st = st;
    if (raw_in == st.out) begin
      next_st.cnt = '0;
    end else if (st.cnt + CNT_W'(1) >= limit) begin
      next_st.out = raw_in;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filt_out = st.out;

  AST_FILT_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(st.out) |-> ($past(st.cnt) + CNT_W'(1) >= $past(limit)) && $past(raw_in) == st.out)
    else $error("filter output changed before the stable time elapsed");

endmodule // fiet_filter
`default_nettype wire

// ===== src/fiet_delay_mem.sv
// Circular delay memory giving a fixed latency on a word stream
`default_nettype none
module fiet_delay_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int DELAY = 200
) (
  input wire logic clock, // 200 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [WIDTH-1:0] wdata, // Word written every cycle
  output logic [WIDTH-1:0] rdata // Word from DELAY cycles ago
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [WIDTH-1:0] rdata;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } fiet_mem_state_type;

  fiet_mem_state_type st;
  fiet_mem_state_type next_st;

  if (DELAY < 2 || DELAY > DEPTH || DEPTH != (1 << AW)) begin : g_chk
    $error("fiet_delay_mem: DELAY or DEPTH unusable");
  end

  always_comb begin
    next_st = st;
    next_st.mem[st.wptr] = wdata;
    next_st.rdata = st.mem[st.wptr - AW'(DELAY - 1)];
    next_st.wptr = st.wptr + AW'(1);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

endmodule // fiet_delay_mem
`default_nettype wire

// ===== verification/fiet_cpu_model.sv
// Controller CPU model: record writes, image reads, boot pulse and service acks
`default_nettype none
module fiet_cpu_model (
  input wire logic clock, // Module clock
  input wire fiet_pkg::fiet_img_rsp_type img_rsp, // Read answer
  output fiet_pkg::fiet_rec_wr_type rec_wr, // Record byte write
  output fiet_pkg::fiet_img_req_type img_req, // Image byte read
  output logic cpu_boot, // Boot pulse
  output logic [15:0] proc_irq_ack // Service done per channel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rec_wr = '0;
    img_req = '0;
    cpu_boot = 1'b0;
    proc_irq_ack = '0;
  end

  // Released fields carry the inverse of the last value
  task automatic wr(input logic [7:0] num, input logic [6:0] idx, input logic [7:0] data);
    @(posedge clock);
    #1 rec_wr = '{valid: 1'b1, num: num, idx: idx, data: data};
    @(posedge clock);
    #1 rec_wr = '{valid: 1'b0, num: ~num, idx: ~idx, data: ~data};
  endtask

  task automatic rd(input logic [5:0] addr, output logic [7:0] data);
    @(posedge clock);
    #1 img_req = '{valid: 1'b1, addr: addr};
    @(posedge clock);
    #1 img_req = '{valid: 1'b0, addr: ~addr};
    data = (img_rsp.valid === 1'b1) ? img_rsp.data : 8'hXX;
  endtask

  task automatic boot;
    @(posedge clock);
    #1 cpu_boot = 1'b1;
    @(posedge clock);
    #1 cpu_boot = 1'b0;
  endtask

  // Service of a channel ends only when the bench says so
  task automatic ack(input int ch);
    @(posedge clock);
    #1 proc_irq_ack[ch] = 1'b1;
    @(posedge clock);
    #1 proc_irq_ack[ch] = 1'b0;
  endtask
endmodule // fiet_cpu_model
`default_nettype wire

// ===== verification/test_fiet_top.sv
// Self-checking bench for the fast input edge time-stamp block
`default_nettype none
module test_fiet_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 4;
  localparam int TICK = 4;
  logic clock;
  logic sys_rst;
  logic ext_mode;
  logic cpu_boot;
  logic [15:0] pin_in;
  fiet_pkg::fiet_rec_wr_type rec_wr;
  fiet_pkg::fiet_img_req_type img_req;
  logic [15:0] proc_irq_ack;
  fiet_pkg::fiet_img_rsp_type img_rsp;
  logic [15:0] proc_irq_vec;
  logic diag_irq;
  logic [15:0] diag_chan;
  int n_mismatch;
  int checks_done;
  int cyc;
  int n_irq [16];
  int n_diag;
  logic [15:0] diag_seen;
  int irq_cyc;
  int boot_cyc;
  int t0;
  logic [7:0] rd;
  logic [15:0] stamp;
  logic [15:0] stamp2;
  logic [22:0] cfg [11];

  fiet_top #(.STEP_CYCLES(STEP), .DELAY_CYCLES(4), .TICK_CYCLES(TICK), .DELAY_DEPTH(256)) dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .ext_mode(ext_mode),
    .cpu_boot(cpu_boot),
    .pin_in(pin_in),
    .rec_wr(rec_wr),
    .img_req(img_req),
    .proc_irq_ack(proc_irq_ack),
    .img_rsp(img_rsp),
    .proc_irq_vec(proc_irq_vec),
    .diag_irq(diag_irq),
    .diag_chan(diag_chan)
  );

  fiet_cpu_model cpu (
    .clock(clock),
    .img_rsp(img_rsp),
    .rec_wr(rec_wr),
    .img_req(img_req),
    .cpu_boot(cpu_boot),
    .proc_irq_ack(proc_irq_ack)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_win(input logic [15:0] got, input int lo, input int hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: value %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic pin(input int ch, input logic v);
    @(posedge clock);
    #1 pin_in[ch] = v;
  endtask

  // Long enough for sync, delay line, filter and edge stage
  task automatic settle;
    repeat (40) @(posedge clock);
  endtask

  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      n_mismatch++;
      summarize();
    end
    for (int i = 0; i < 16; i++) begin
      if (proc_irq_vec[i] === 1'b1) begin
        n_irq[i]++;
        irq_cyc = cyc;
      end
    end
    if (diag_irq === 1'b1) begin
      n_diag++;
      diag_seen = diag_seen | diag_chan;
    end
  end

  initial begin
    sys_rst = 1'b1;
    ext_mode = 1'b0;
    pin_in = '0;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    n_diag = 0;
    diag_seen = '0;
    irq_cyc = 0;
    foreach (n_irq[i]) n_irq[i] = 0;
    cfg = '{{8'h7F, 7'h00, 8'h00}, {8'h7F, 7'h01, 8'h01}, {8'h80, 7'h00, 8'h01},
            {8'h80, 7'h01, 8'h02}, {8'h80, 7'h02, 8'h03}, {8'h80, 7'h03, 8'h00},
            {8'h80, 7'h10, 8'h01}, {8'h81, 7'h00, 8'h00}, {8'h81, 7'h01, 8'h02},
            {8'h7F, 7'h02, 8'hFF}, {8'h80, 7'h12, 8'h03}};
    repeat (16) @(posedge clock);
    #1 sys_rst = 1'b0;
    // Basic mode: level only, no edge events
    cpu.rd(6'h00, rd);
    cmp8(rd, 8'h00);
    pin(0, 1'b1);
    settle();
    cpu.rd(6'h00, rd);
    cmp8(rd, 8'h01);
    cpu.rd(6'h04, rd);
    cmp8(rd, 8'h00);
    cmp_win(16'(n_irq[0]), 0, 0);
    cpu.wr(8'h80, 7'h10, 8'h02);
    pin(0, 1'b0);
    settle();
    // Extended mode with runtime records
    #1 ext_mode = 1'b1;
    repeat (2) @(posedge clock);
    cpu.boot();
    boot_cyc = cyc;
    foreach (cfg[i]) cpu.wr(cfg[i][22:15], cfg[i][14:8], cfg[i][7:0]);
    pin(0, 1'b1);
    t0 = cyc;
    for (int k = 0; k < 100 && n_irq[0] == 0; k++) @(posedge clock);
    #1 cmp_win(16'(irq_cyc - t0), 2 * STEP + 3, 2 * STEP + 12);
    cpu.rd(6'h0C, stamp[7:0]);
    cpu.rd(6'h0D, stamp[15:8]);
    cmp_win(stamp, (irq_cyc - boot_cyc) / TICK - 2, (irq_cyc - boot_cyc) / TICK + 2);
    cpu.rd(6'h04, rd);
    cmp8(rd, 8'h01);
    cpu.rd(6'h04, rd);
    cmp8(rd, 8'h00);
    // Pulse shorter than the filter is dropped
    pin(0, 1'b0);
    repeat (2) @(posedge clock);
    pin(0, 1'b1);
    settle();
    cmp_win(16'(n_irq[0]), 1, 1);
    cpu.rd(6'h00, rd);
    cmp8(rd, 8'h01);
    // Falling-only channel, two unread edges
    pin(1, 1'b1);
    settle();
    cmp_win(16'(n_irq[1]), 0, 0);
    pin(1, 1'b0);
    settle();
    cmp_win(16'(n_irq[1]), 1, 1);
    cpu.rd(6'h04, rd);
    cmp8(rd, 8'h02);
    cpu.rd(6'h08, rd);
    cmp8(rd, 8'h02);
    // Both-edge channel retriggers while still serviced
    pin(2, 1'b1);
    settle();
    pin(2, 1'b0);
    settle();
    cmp_win(16'(n_irq[2]), 2, 2);
    cmp_win(16'(n_diag), 1, 1);
    cmp8(diag_seen[7:0], 8'h04);
    cpu.ack(2);
    pin(2, 1'b1);
    settle();
    cmp_win(16'(n_diag), 1, 1);
    cpu.wr(8'h7F, 7'h01, 8'h00);
    pin(2, 1'b0);
    settle();
    cmp_win(16'(n_irq[2]), 4, 4);
    cmp_win(16'(n_diag), 1, 1);
    cpu.rd(6'h10, stamp2[7:0]);
    cpu.rd(6'h11, stamp2[15:8]);
    cmp_win(stamp2, (irq_cyc - boot_cyc) / TICK - 2, (irq_cyc - boot_cyc) / TICK + 2);
    // Rising-only stamp keeps its value on a fall
    pin(0, 1'b0);
    settle();
    cpu.rd(6'h0C, rd);
    cmp8(rd, stamp[7:0]);
    cpu.rd(6'h02, rd);
    cmp8(rd, 8'h00);
    cpu.rd(6'h2F, rd);
    cmp8(rd, 8'h00);
    summarize();
  end
endmodule // test_fiet_top
`default_nettype wire
